// ---- logic/serial_dac_channel_load.sv ----
// Serial input ports, input latches and converter latches for two channels.
//
// Notes on behaviour
// - A falling load strobe copies the channel's input latch into its converter latch.
// - With the load strobe held low, the copy happens when the sixteenth bit is taken.
// - A falling frame sync starts a word and bits are accepted only after it.
// - A data bit is sampled on each falling shift clock edge while frame sync is low.
// - The three top code bits become a seven-switch thermometer for the coarse segment.
// - The remaining low bits, nine or eleven, drive the binary ladder directly.
// - A frame holds sixteen bits, leading don't-care bits first, then the code MSB first.
// - Shift clock edges after the sixteenth are ignored until frame sync rises again.
// - A load strobe falling mid-word does nothing then, and updates at the end only if low.
// - The converter code is a two's complement value.
`timescale 1ns/10ps
`default_nettype none

module serial_dac_channel_load #(
   parameter bit narrow_variant = 1'b0
) (
   input  wire logic                 clk,
   input  wire logic                 sys_rst,
   input  wire logic                 shift_clock_a,
   input  wire logic                 frame_sync_a_n,
   input  wire logic                 serial_in_a,
   input  wire logic                 load_strobe_a_n,
   input  wire logic                 shift_clock_b,
   input  wire logic                 frame_sync_b_n,
   input  wire logic                 serial_in_b,
   input  wire logic                 load_strobe_b_n,
   output dac_pkg::dac_out_type      dac_out_a,
   output dac_pkg::dac_out_type      dac_out_b
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin gathering and decode helper.

   logic [dac_pkg::CHANNELS-1:0] shift_clock;
   logic [dac_pkg::CHANNELS-1:0] frame_sync_n;
   logic [dac_pkg::CHANNELS-1:0] serial_in;
   logic [dac_pkg::CHANNELS-1:0] load_strobe_n;
   dac_pkg::dac_out_type         dac_out_q [dac_pkg::CHANNELS];

   // Channel pins are collected so that one loop builds both ports.
   assign shift_clock   = {shift_clock_b, shift_clock_a};
   assign frame_sync_n  = {frame_sync_b_n, frame_sync_a_n};
   assign serial_in     = {serial_in_b, serial_in_a};
   assign load_strobe_n = {load_strobe_b_n, load_strobe_a_n};
   assign dac_out_a     = dac_out_q[0];
   assign dac_out_b     = dac_out_q[1];

   // Splits a received word into the signed code, coarse switches and ladder bits.
   function automatic dac_pkg::dac_out_type split_word(input dac_pkg::word_type w);
      dac_pkg::dac_out_type o;
      logic [dac_pkg::MSB_W-1:0] top;
      logic [dac_pkg::MSB_W-1:0] level;
      o = '0;
      if (narrow_variant) begin
         // Low twelve bits carry the code; sign extend it to the common width.
         o.code = {{2{w[dac_pkg::CODE_W_NARROW-1]}}, w[dac_pkg::CODE_W_NARROW-1:0]};
         top = w[dac_pkg::CODE_W_NARROW-1 -: dac_pkg::MSB_W];
         o.ladder = {2'h0, w[dac_pkg::LADDER_W_NARROW-1:0]};
      end else begin
         o.code = w[dac_pkg::CODE_W_WIDE-1:0];
         top = w[dac_pkg::CODE_W_WIDE-1 -: dac_pkg::MSB_W];
         o.ladder = w[dac_pkg::LADDER_W_WIDE-1:0];
      end
      // Inverting the sign bit turns the signed top bits into a 0..7 level.
      level = {~top[dac_pkg::MSB_W-1], top[dac_pkg::MSB_W-2:0]};
      for (int i = 0; i < dac_pkg::SEG_W; i++) begin
         o.segment[i] = (level > i[dac_pkg::MSB_W-1:0]);
      end
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // One independent serial port and latch pair per channel.

   for (genvar g = 0; g < dac_pkg::CHANNELS; g++) begin : chan

      // Link domain state, clocked by the host's shift clock.
      logic [dac_pkg::CNT_W-1:0] bit_count_q;
      logic                      word_full_q;
      dac_pkg::word_type         shift_q;

      // Clock domain state.
      logic              fs_meta_q;
      logic              fs_sync_q;
      logic              full_meta_q;
      logic              full_sync_q;
      logic              full_prev_q;
      logic              ld_meta_q;
      logic              ld_sync_q;
      logic              ld_prev_q;
      dac_pkg::word_type in_latch_q;
      logic              word_done;
      logic              load_fall;
      logic              shifting;

      // Bit counter; a high frame sync holds it cleared so a word only begins after it falls.
      always_ff @(negedge shift_clock[g] or posedge frame_sync_n[g]) begin
         if (frame_sync_n[g]) begin
            bit_count_q <= dac_pkg::COUNT_RESET;
            word_full_q <= 1'b0;
         end else if (bit_count_q != dac_pkg::FRAME_COUNT) begin
            bit_count_q <= bit_count_q + 5'h01;
            word_full_q <= (bit_count_q == dac_pkg::FRAME_COUNT - 5'h01);
         end
      end

      // Shift register is copied into the separate input latch; it freezes after sixteen bits.
      always_ff @(negedge shift_clock[g]) begin
         if (!frame_sync_n[g] && bit_count_q != dac_pkg::FRAME_COUNT) begin
            shift_q <= {shift_q[dac_pkg::WORD_W-2:0], serial_in[g]};
         end
      end

      // Two-stage synchronisers for frame sync, word-complete level and load strobe.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            fs_meta_q   <= 1'b1;
            fs_sync_q   <= 1'b1;
            full_meta_q <= 1'b0;
            full_sync_q <= 1'b0;
            full_prev_q <= 1'b0;
            ld_meta_q   <= 1'b1;
            ld_sync_q   <= 1'b1;
            ld_prev_q   <= 1'b1;
         end else begin
            fs_meta_q   <= frame_sync_n[g];
            fs_sync_q   <= fs_meta_q;
            full_meta_q <= word_full_q;
            full_sync_q <= full_meta_q;
            full_prev_q <= full_sync_q;
            ld_meta_q   <= load_strobe_n[g];
            ld_sync_q   <= ld_meta_q;
            ld_prev_q   <= ld_sync_q;
         end
      end

      // Events seen in the clock domain.
      assign word_done = full_sync_q & ~full_prev_q;
      assign load_fall = ld_prev_q & ~ld_sync_q;
      assign shifting  = ~fs_sync_q & ~full_sync_q;

      // Input latch copy; the shift word is frozen while the full level stands.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            in_latch_q <= dac_pkg::WORD_RESET;
         end else if (word_done) begin
            in_latch_q <= shift_q;
         end
      end

      // Converter latch update on load strobe fall, or at word end with the strobe low.
      always_ff @(posedge clk) begin
         if (sys_rst) begin
            dac_out_q[g] <= split_word(dac_pkg::WORD_RESET);
         end else if (word_done && !ld_sync_q) begin
            dac_out_q[g] <= split_word(shift_q);
         end else if (load_fall && !shifting) begin
            dac_out_q[g] <= split_word(in_latch_q);
         end
      end
   end

endmodule

`default_nettype wire

// ---- common/dac_pkg.sv ----
// Shared constants and types for the dual serial converter front end.
package dac_pkg;

   // Serial frame shape.
   localparam int          CHANNELS     = 2;
   localparam int          WORD_W       = 16;
   localparam int          CNT_W        = 5;
   localparam logic [4:0]  FRAME_COUNT  = 5'h10;   // Bits accepted per frame.
   localparam logic [4:0]  COUNT_RESET  = 5'h00;

   // Converter code layout.
   localparam int          CODE_W_WIDE    = 14;
   localparam int          CODE_W_NARROW  = 12;
   localparam int          MSB_W          = 3;
   localparam int          SEG_W          = 7;
   localparam int          LADDER_W_WIDE  = 11;
   localparam int          LADDER_W_NARROW = 9;

   // Reset values.
   localparam logic [15:0] WORD_RESET   = 16'h0000;

   typedef logic [WORD_W-1:0] word_type;

   // What one channel presents to its converter core.
   typedef struct packed {
      logic signed [CODE_W_WIDE-1:0]   code;      // Two's complement code, sign extended.
      logic        [SEG_W-1:0]         segment;   // Coarse thermometer switches.
      logic        [LADDER_W_WIDE-1:0] ladder;    // Binary ladder switches.
   } dac_out_type;

endpackage

// ---- test/dac_load_sva.sv ----
// Checker for the converter outputs of both channels.
`timescale 1ns/10ps
`default_nettype none
module dac_load_chk #(parameter bit narrow_variant = 1'b0) (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 load_strobe_a_n,
   input wire logic                 load_strobe_b_n,
   input wire dac_pkg::dac_out_type dac_out_a,
   input wire dac_pkg::dac_out_type dac_out_b
);
   // Switch patterns expected from a code.
   function automatic logic [6:0] seg(dac_pkg::dac_out_type o);
      logic [2:0] l;
      l = narrow_variant ? {~o.code[11], o.code[10:9]} : {~o.code[13], o.code[12:11]};
      return 7'((8'h01 << l) - 8'h01);
   endfunction
   function automatic logic [10:0] lad(dac_pkg::dac_out_type o);
      return narrow_variant ? {2'h0, o.code[8:0]} : o.code[10:0];
   endfunction
   // A load needs the strobe pin low two clocks earlier.
   sequence s_low(s);
      $past(s, 2) == 1'b0;
   endsequence
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_seg_a: assert property (dac_out_a.segment == seg(dac_out_a)) else $error("seg a");
   a_seg_b: assert property (dac_out_b.segment == seg(dac_out_b)) else $error("seg b");
   a_lad_a: assert property (dac_out_a.ladder == lad(dac_out_a)) else $error("lad a");
   a_lad_b: assert property (dac_out_b.ladder == lad(dac_out_b)) else $error("lad b");
   a_load_a: assert property ($changed(dac_out_a.code) |-> s_low(load_strobe_a_n))
      else $error("load a");
   a_load_b: assert property ($changed(dac_out_b.code) |-> s_low(load_strobe_b_n))
      else $error("load b");
   a_rst_a: assert property (disable iff (1'b0) sys_rst |=> dac_out_a.code == 14'h0000)
      else $error("rst a");
   a_rst_b: assert property (disable iff (1'b0) sys_rst |=> dac_out_b.code == 14'h0000)
      else $error("rst b");
endmodule
bind serial_dac_channel_load dac_load_chk #(.narrow_variant(narrow_variant)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .load_strobe_a_n(load_strobe_a_n),
   .load_strobe_b_n(load_strobe_b_n), .dac_out_a(dac_out_a), .dac_out_b(dac_out_b));
`default_nettype wire

// ---- test/host_tx_model.sv ----
// Host serial transmit port that frames words for one channel.
`timescale 1ns/10ps
`default_nettype none
module host_tx_model (
   output var logic shift_clock,
   output var logic frame_sync_n,
   output var logic serial_in
);
   // Idle: clock stands high, frame sync high.
   initial begin
      shift_clock = 1'b1;
      frame_sync_n = 1'b1;
      serial_in = 1'b0;
   end
   // Frame sync falls, then bits go out MSB first on a 48 ns clock.
   task automatic send(input logic [15:0] w, input int n);
      frame_sync_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         serial_in = w[15 - (i % 16)];
         #24 shift_clock = 1'b0;
         #24 shift_clock = 1'b1;
      end
      // Hold frame sync so the word can cross, then let the data line wander.
      #48 frame_sync_n = 1'b1;
      serial_in = ~serial_in;
   endtask
endmodule
`default_nettype wire

// ---- test/test_serial_dac_channel_load.sv ----
// Self-checking bench for both converter channels.
`timescale 1ns/10ps
`default_nettype none
module test_serial_dac_channel_load;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic load_strobe_a_n = 1'b1;
   logic load_strobe_b_n = 1'b1;
   wire logic shift_clock_a, frame_sync_a_n, serial_in_a, shift_clock_b, frame_sync_b_n, serial_in_b;
   dac_pkg::dac_out_type dac_out_a, dac_out_b;
   int fails = 0;
   int num_checks = 0;
   always #5 clk = ~clk;
   serial_dac_channel_load u_dut (.clk(clk), .sys_rst(sys_rst), .shift_clock_a(shift_clock_a),
      .frame_sync_a_n(frame_sync_a_n), .serial_in_a(serial_in_a), .load_strobe_a_n(load_strobe_a_n),
      .shift_clock_b(shift_clock_b), .frame_sync_b_n(frame_sync_b_n), .serial_in_b(serial_in_b),
      .load_strobe_b_n(load_strobe_b_n), .dac_out_a(dac_out_a), .dac_out_b(dac_out_b));
   host_tx_model u_host_a (.shift_clock(shift_clock_a), .frame_sync_n(frame_sync_a_n),
      .serial_in(serial_in_a));
   host_tx_model u_host_b (.shift_clock(shift_clock_b), .frame_sync_n(frame_sync_b_n),
      .serial_in(serial_in_b));
   // Compare one code and count it.
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // A four-clock strobe pulse on channel a, then four more clocks with the strobe high.
   task automatic pulse_a;
      @(negedge clk) load_strobe_a_n = 1'b0;
      repeat (4) @(negedge clk);
      load_strobe_a_n = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   // Seventeen edges with the strobe high, then a strobe pulse loads a negative code.
   task automatic s_strobe;
      u_host_a.send(16'hea01, 17);
      chk(dac_out_a.code, 14'h0000);
      pulse_a();
      chk(dac_out_a.code, 14'h2a01);
   endtask
   // Strobe falls mid-frame and stays low: load at word end, other channel untouched.
   task automatic s_held;
      fork
         u_host_b.send(16'h1234, 16);
         #200 @(negedge clk) load_strobe_b_n = 1'b0;
      join
      repeat (3) @(negedge clk);
      chk(dac_out_b.code, 14'h1234);
      chk(dac_out_a.code, 14'h2a01);
   endtask
   // Strobe falls and rises mid-frame: no load until the next pulse.
   task automatic s_abort;
      fork
         u_host_a.send(16'h0155, 16);
         #200 pulse_a();
      join
      repeat (3) @(negedge clk);
      chk(dac_out_a.code, 14'h2a01);
      pulse_a();
      chk(dac_out_a.code, 14'h0155);
   endtask
   // Reset for three clocks, then the scenarios.
   initial begin
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      s_strobe();
      s_held();
      s_abort();
      final_report();
   end
   // Guard against a hang.
   initial begin
      #100000;
      fails++;
      final_report();
   end
endmodule
`default_nettype wire
